// *** bench/exec_monitor.sv ***
// Checker for the move and branch execution block.
// Assumes it is bound to move_branch_exec and sees only that module's ports.
module exec_monitor
  import exec_pkg::*;
(
  input wire logic              mclk,        // Core clock.
  input wire logic              reset,       // Asynchronous reset.
  input wire logic              instr_valid, // Instruction present.
  input wire instr_t            instr,       // Instruction fields.
  input wire logic [DATA_W-1:0] file_rdata,  // File read value.
  input wire logic [PC_W-1:0]   pc,          // Program counter.
  input wire logic [DATA_W-1:0] work,        // Work register.
  input wire logic              zero_flag,   // Zero flag.
  input wire logic              busy,        // Flush cycle.
  input wire wr_t               file_wr,     // File write.
  input wire wr_t               sfr_wr,      // Special write.
  input wire logic [STK_W-1:0]  stk_level,   // Stack level.
  input wire logic [PC_W-1:0]   stk_top      // Stack top.
);
  timeunit 1ns;
  timeprecision 1ns;
  // Every check runs on the core clock and rests while reset is high. An instruction
  // is taken only on an edge with valid high and no flush under way, and each
  // antecedent but that of chk_flush_idle spells that out on sampled values rather than trusting the opcode.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  chk_sfr_load: assert property (
    instr_valid && !busy && instr.op == OP_SPECIAL_REG_LOAD && instr.saddr >= SFR_LO |=>
    sfr_wr == {1'b1, 3'h0, $past(instr.saddr), $past(work)}) else $error("bad sfr write");
  chk_sfr_range: assert property (
    instr_valid && !busy && instr.op == OP_SPECIAL_REG_LOAD && instr.saddr < SFR_LO |=>
    !sfr_wr.we) else $error("sfr write outside the page");
  chk_call_push: assert property (
    instr_valid && !busy && instr.op == OP_LONG_SUBROUTINE_CALL |=>
    stk_top == $past(pc) + 11'h001) else $error("bad return address");
  chk_call_target: assert property (
    instr_valid && !busy && instr.op == OP_LONG_SUBROUTINE_CALL |=>
    pc == $past(instr.target) && busy ##1 !busy) else $error("bad call target");
  chk_call_level: assert property (
    instr_valid && !busy && instr.op == OP_LONG_SUBROUTINE_CALL |=>
    stk_level == $past(stk_level) + 3'h1) else $error("bad stack level");
  chk_jump_target: assert property (
    instr_valid && !busy && instr.op == OP_LONG_JUMP |=> pc == $past(instr.target)
    && busy && $stable(stk_level) && $stable(stk_top)) else $error("bad jump");
  chk_flush_idle: assert property (
    busy |=> $stable(work) && $stable(pc) && !file_wr.we && !sfr_wr.we)
    else $error("instruction taken during flush");
  chk_imm_load: assert property (
    instr_valid && !busy && instr.op == OP_IMMEDIATE_TO_WORK |=>
    work == $past(instr.imm) && $stable(zero_flag)) else $error("bad immediate load");
  chk_file_store: assert property (
    instr_valid && !busy && instr.op == OP_WORK_TO_FILE |=>
    file_wr == {1'b1, $past(instr.faddr), $past(work)}) else $error("bad file store");
  chk_move_dest: assert property (
    instr_valid && !busy && instr.op == OP_FILE_MOVE |=> ($past(instr.dest) ?
    (file_wr.we && file_wr.addr == $past(instr.faddr) && file_wr.data == $past(file_rdata)) :
    work == $past(file_rdata))) else $error("bad move destination");
  chk_move_zero: assert property (
    instr_valid && !busy && instr.op == OP_FILE_MOVE |=>
    zero_flag == ($past(file_rdata) == 8'h00)) else $error("bad zero flag");
endmodule
bind move_branch_exec exec_monitor mon_u (.mclk, .reset, .instr_valid, .instr, .file_rdata,
  .pc, .work, .zero_flag, .busy, .file_wr, .sfr_wr, .stk_level, .stk_top);

// *** bench/testbench.sv ***
// Self-checking bench for the move and branch execution block.
// Assumes the bench plays both the decoder and the data file.
module testbench
  import exec_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic              mclk = 1'b0;
  logic              reset = 1'b1;
  logic              instr_valid = 1'b0;
  instr_t            instr = '0;
  logic [DATA_W-1:0] file_rdata = 8'h00;
  logic [PC_W-1:0]   pc, stk_top;
  logic [DATA_W-1:0] work;
  logic              zero_flag, busy;
  wr_t               file_wr, sfr_wr;
  logic [STK_W-1:0]  stk_level;
  int                fail_count = 0, check_count = 0;
  // Free-running core clock, 40 ns period.
  always #20 mclk = ~mclk;
  move_branch_exec dut_u (.mclk, .reset, .instr_valid, .instr, .file_rdata, .pc, .work,
    .zero_flag, .busy, .file_wr, .sfr_wr, .stk_level, .stk_top);
  // Compares one result; wide enough for the widest group of outputs packed together.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Holds one instruction up to the edge that takes it; results are settled on return.
  // The target also feeds both addresses, which keeps the call sites short.
  task automatic run(input op_t op, input logic [10:0] t, input logic [7:0] v, input logic d);
    @(posedge mclk) #1;
    instr_valid = 1'b1;
    instr = '{op, t, v, t[6:0], t[3:0], d};
    @(posedge mclk) #1;
    instr_valid = 1'b0;
  endtask
  // One-cycle moves through the work register and both write paths.
  task automatic t_moves();
    run(OP_IMMEDIATE_TO_WORK, 11'h000, 8'haa, 1'b0);
    chk(work, 8'haa);
    run(OP_SPECIAL_REG_LOAD, 11'h00f, 8'h00, 1'b0);
    chk(sfr_wr, {1'b1, 7'h0f, 8'haa});
    run(OP_SPECIAL_REG_LOAD, 11'h004, 8'h00, 1'b0);
    chk(sfr_wr.we, 1'b0);
    run(OP_WORK_TO_FILE, 11'h07f, 8'h00, 1'b0);
    chk(file_wr, {1'b1, 7'h7f, 8'haa});
  endtask
  // File move to both destinations; the zero flag follows the moved value only.
  task automatic t_file();
    run(OP_FILE_MOVE, 11'h012, 8'h00, 1'b1);
    chk({file_wr, work}, {1'b1, 7'h12, 8'h00, 8'haa});
    chk(zero_flag, 1'b1);
    run(OP_IMMEDIATE_TO_WORK, 11'h000, 8'h55, 1'b0);
    chk({zero_flag, work}, {1'b1, 8'h55});
    file_rdata = 8'h3c;
    run(OP_FILE_MOVE, 11'h012, 8'h00, 1'b0);
    chk({file_wr.we, work}, {1'b0, 8'h3c});
    chk(zero_flag, 1'b0);
  endtask
  // A jump to the top address makes the following call's return address wrap to zero.
  task automatic t_branch();
    run(OP_LONG_JUMP, 11'h7ff, 8'h00, 1'b0);
    chk({busy, stk_level, pc}, {1'b1, 3'h0, 11'h7ff});
    run(OP_LONG_SUBROUTINE_CALL, 11'h123, 8'h00, 1'b0);
    chk(pc, 11'h123);
    chk({stk_level, stk_top}, {3'h1, 11'h000});
    run(OP_LONG_SUBROUTINE_CALL, 11'h000, 8'h00, 1'b0);
    chk({stk_level, stk_top, pc}, {3'h2, 11'h124, 11'h000});
  endtask
  // A load held up across the flush edge of a jump must be dropped, not executed.
  task automatic t_refuse();
    @(posedge mclk) #1;
    instr_valid = 1'b1;
    instr = '{OP_LONG_JUMP, 11'h055, 8'h00, 7'h00, 4'h0, 1'b0};
    @(posedge mclk) #1;
    chk({busy, pc}, {1'b1, 11'h055});
    instr = '{OP_IMMEDIATE_TO_WORK, 11'h000, 8'h99, 7'h00, 4'h0, 1'b0};
    @(posedge mclk) #1;
    instr_valid = 1'b0;
    chk({busy, stk_level, pc, work}, {1'b0, 3'h2, 11'h055, 8'h3c});
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Reset for six cycles, then the scenarios in turn.
  initial begin
    repeat (6) @(posedge mclk);
    #1 reset = 1'b0;
    t_moves();
    t_file();
    t_branch();
    t_refuse();
    summarize();
  end
  // The scenarios need well under a hundred cycles; this cuts a hang short.
  initial begin
    #20000;
    fail_count++;
    summarize();
  end
endmodule

// *** logic/move_branch_exec.sv ***
// Execution unit for register moves, subroutine call and long jump.
// Assumes the decoder presents instr with instr_valid while busy is low,
// and file_rdata returns the file location named by instr.faddr combinationally.
module move_branch_exec
  import exec_pkg::*;
(
  input  wire logic               mclk,         // Core clock, one instruction cycle.
  input  wire logic               reset,        // Asynchronous reset, active high.
  input  wire logic               instr_valid,  // Decoded instruction present.
  input  wire instr_t             instr,        // Decoded instruction fields.
  input  wire logic [DATA_W-1:0]  file_rdata,   // Data file read value at instr.faddr.
  output logic [PC_W-1:0]         pc,           // Program counter.
  output logic [DATA_W-1:0]       work,         // Work register.
  output logic                    zero_flag,    // Zero flag.
  output logic                    busy,         // Second cycle of a two-cycle op.
  output wr_t                     file_wr,      // Data file write.
  output wr_t                     sfr_wr,       // Special-register page write.
  output logic [STK_W-1:0]        stk_level,    // Return stack level.
  output logic [PC_W-1:0]         stk_top       // Top entry of the return stack.
);

  // Sequencer states: RUN takes instructions, FLUSH is the second cycle of a branch.
  typedef enum logic [0:0] {
    ST_RUN,
    ST_FLUSH
  } st_t;

  // Sequencer, busy marker and program counter.
  st_t                 st_r;
  st_t                 st_nxt;
  logic                busy_r;
  logic                busy_nxt;
  logic [PC_W-1:0]     pc_r;
  logic [PC_W-1:0]     pc_nxt;

  // Work register and zero flag.
  logic [DATA_W-1:0]   work_r;
  logic [DATA_W-1:0]   work_nxt;
  logic                z_r;
  logic                z_nxt;

  // One-cycle write strobes toward the data file and the special-register page.
  wr_t                 fw_r;
  wr_t                 fw_nxt;
  wr_t                 sw_r;
  wr_t                 sw_nxt;

  // Return stack: level, a registered copy of the top entry, and the entries.
  logic [STK_W-1:0]    lvl_r;
  logic [STK_W-1:0]    lvl_nxt;
  logic [PC_W-1:0]     top_r;
  logic [PC_W-1:0]     top_nxt;
  logic [PC_W-1:0]     stk_r [STK_DEPTH];

  // Decode shared by every group of state.
  logic                take;
  logic                sfr_in_page;
  logic                push;
  logic [PC_W-1:0]     ret_addr;

  // An instruction counts only in RUN: what the decoder shows during the flush
  // cycle is the stale fetch behind a branch and must not reach any state.
  always_comb begin
    take        = instr_valid && (st_r == ST_RUN);
    sfr_in_page = (instr.saddr >= SFR_LO) && (instr.saddr <= SFR_HI);
    push        = take && (instr.op == OP_LONG_SUBROUTINE_CALL);
    ret_addr    = PC_W'(pc_r + 11'h001);
  end

  // Program counter and sequencer. A call or jump spends one flush cycle after
  // the taking edge, so each branch totals two cycles while the target is fetched.
  always_comb begin
    st_nxt   = ST_RUN;
    busy_nxt = 1'b0;
    pc_nxt   = pc_r;
    if (take) begin
      case (instr.op)
        OP_LONG_SUBROUTINE_CALL: begin
          pc_nxt   = instr.target;
          st_nxt   = ST_FLUSH;
          busy_nxt = 1'b1;
        end
        OP_LONG_JUMP: begin
          pc_nxt   = instr.target;
          st_nxt   = ST_FLUSH;
          busy_nxt = 1'b1;
        end
        default: begin
          // Every other taken operation, OP_NONE included, steps to the next word.
          pc_nxt = ret_addr;
        end
      endcase
    end
  end

  // Sequencer registers; busy has its own flop so the port needs no decode.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_r   <= ST_RUN;
      busy_r <= 1'b0;
      pc_r   <= PC_RESET;
    end else begin
      st_r   <= st_nxt;
      busy_r <= busy_nxt;
      pc_r   <= pc_nxt;
    end
  end

  // Work register and zero flag. Only the file move touches the zero flag; the
  // immediate load and the store leave it exactly as it was.
  always_comb begin
    work_nxt = work_r;
    z_nxt    = z_r;
    if (take) begin
      case (instr.op)
        OP_IMMEDIATE_TO_WORK: begin
          work_nxt = instr.imm;
        end
        OP_FILE_MOVE: begin
          if (!instr.dest) begin
            work_nxt = file_rdata;
          end
          z_nxt = (file_rdata == 8'h00);
        end
        default: begin
        end
      endcase
    end
  end

  // Work register and zero flag registers.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      work_r <= WORK_RESET;
      z_r    <= 1'b0;
    end else begin
      work_r <= work_nxt;
      z_r    <= z_nxt;
    end
  end

  // Write strobes. Each stands for one cycle only, so the file and the page see
  // exactly one write per instruction even if they sample on every edge.
  always_comb begin
    fw_nxt = '0;
    sw_nxt = '0;
    if (take) begin
      case (instr.op)
        OP_SPECIAL_REG_LOAD: begin
          // Addresses below the page are ignored rather than aliased onto it.
          if (sfr_in_page) begin
            sw_nxt.we   = 1'b1;
            sw_nxt.addr = FADDR_W'(instr.saddr);
            sw_nxt.data = work_r;
          end
        end
        OP_WORK_TO_FILE: begin
          fw_nxt.we   = 1'b1;
          fw_nxt.addr = instr.faddr;
          fw_nxt.data = work_r;
        end
        OP_FILE_MOVE: begin
          // Writing the value back to its own location makes a zero test.
          if (instr.dest) begin
            fw_nxt.we   = 1'b1;
            fw_nxt.addr = instr.faddr;
            fw_nxt.data = file_rdata;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Write strobe registers.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      fw_r <= '0;
      sw_r <= '0;
    end else begin
      fw_r <= fw_nxt;
      sw_r <= sw_nxt;
    end
  end

  // Stack level and top copy. Between pushes the copy is refreshed from the entry
  // that the level names, which keeps it and the storage in step.
  always_comb begin
    lvl_nxt = lvl_r;
    top_nxt = stk_r[lvl_r];
    if (push) begin
      lvl_nxt = STK_W'(lvl_r + 3'h1);
      top_nxt = ret_addr;
    end
  end

  // Stack level and top registers.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      lvl_r <= STK_RESET;
      top_r <= PC_RESET;
    end else begin
      lvl_r <= lvl_nxt;
      top_r <= top_nxt;
    end
  end

  // Stack entries; the entry written is the new level, so a ninth call wraps onto
  // the oldest entry and overwrites it, as the level counter itself wraps.
  for (genvar i = 0; i < STK_DEPTH; i++) begin : g_stk
    logic [PC_W-1:0] ent_nxt;

    always_comb begin
      ent_nxt = stk_r[i];
      if (push && lvl_nxt == STK_W'(i)) begin
        ent_nxt = ret_addr;
      end
    end

    always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
        stk_r[i] <= PC_RESET;
      end else begin
        stk_r[i] <= ent_nxt;
      end
    end
  end

  // Every output is a register, so nothing downstream sees decode glitches.
  assign pc        = pc_r;
  assign work      = work_r;
  assign zero_flag = z_r;
  assign busy      = busy_r;
  assign file_wr   = fw_r;
  assign sfr_wr    = sw_r;
  assign stk_level = lvl_r;
  assign stk_top   = top_r;

endmodule

// *** shared/exec_pkg.sv ***
// Package for the move and branch execution block: opcodes, widths and layouts.
// Assumes a single core clock where one instruction cycle is one mclk cycle.
package exec_pkg;

  localparam int DATA_W   = 8;
  localparam int PC_W     = 11;
  localparam int FADDR_W  = 7;
  localparam int SADDR_W  = 4;
  localparam int STK_W    = 3;
  localparam int STK_DEPTH = 8;

  // Lowest and highest special-function register index on the F page.
  localparam logic [SADDR_W-1:0] SFR_LO = 4'h5;
  localparam logic [SADDR_W-1:0] SFR_HI = 4'hf;

  localparam logic [PC_W-1:0]    PC_RESET = 11'h000;
  localparam logic [DATA_W-1:0]  WORK_RESET = 8'h00;
  localparam logic [STK_W-1:0]   STK_RESET = 3'h0;

  // Operations this block executes; the decoder outside picks one.
  typedef enum logic [2:0] {
    OP_NONE,
    OP_SPECIAL_REG_LOAD,
    OP_LONG_SUBROUTINE_CALL,
    OP_LONG_JUMP,
    OP_IMMEDIATE_TO_WORK,
    OP_WORK_TO_FILE,
    OP_FILE_MOVE
  } op_t;

  // One decoded instruction as handed to the execution block.
  typedef struct packed {
    op_t                  op;
    logic [PC_W-1:0]      target;
    logic [DATA_W-1:0]    imm;
    logic [FADDR_W-1:0]   faddr;
    logic [SADDR_W-1:0]   saddr;
    logic                 dest;
  } instr_t;

  // A write toward data file or special-register page.
  typedef struct packed {
    logic                 we;
    logic [FADDR_W-1:0]   addr;
    logic [DATA_W-1:0]    data;
  } wr_t;

endpackage
